// File: shared/three_wire_pkg.sv
// constants and types shared by both ends of the three-wire serial link
package three_wire_pkg;

  // register map, byte addresses on the cpu side
  localparam logic [15:0] MODE_ADDR     = 16'hFF72; // serial_mode_reg
  localparam logic [15:0] BAUD_ADDR     = 16'hFF73; // baud_prescale_control
  localparam logic [15:0] TX_ADDR       = 16'hFF74; // tx_shift_reg / rx_buffer_reg
  localparam logic [15:0] UART_ADDR     = 16'hFF70; // uart_mode_reg
  localparam logic [15:0] IRQ_FLAG_ADDR = 16'hFFE0; // request flags
  localparam logic [15:0] IRQ_MASK_ADDR = 16'hFFE4; // mask flags

  // field positions
  localparam int MODE_ENABLE_BIT = 7; // serial_enable_bit
  localparam int MODE_ORDER_BIT  = 2; // bit_order_bit, 1 = lsb first
  localparam int MODE_CLKSRC_BIT = 1; // clock_source_bit, 1 = internal
  localparam int BAUD_SEL_LSB    = 4; // prescale_sel_bit0
  localparam int BAUD_SEL_MSB    = 7; // prescale_sel_bit3
  localparam int IRQ_RX_BIT      = 4; // rx_req_flag / rx_mask_flag

  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] UART_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // shared interrupt slot
  localparam logic [15:0] IRQ_VECTOR   = 16'h000C;
  localparam logic [3:0]  IRQ_PRIORITY = 4'h4;

  // transfer and clock constants
  localparam logic [3:0] FRAME_BITS  = 4'h8;
  localparam logic [3:0] SEL_MAX     = 4'h7; // largest legal prescale code
  localparam int         CLK_MHZ     = 250;
  localparam int         PERIOD_NS   = 4;
  localparam int         FIFO_DEPTH  = 8;
  localparam int         FIFO_WIDTH  = 8;
  localparam logic [8:0] HALF_MAX    = 9'h100; // half period cap for n = 7

  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_LOW  = 2'b01,
    XF_HIGH = 2'b11
  } xfer_state_t;

endpackage

// File: shared/three_wire_if.sv
// three-wire link between the device end and the peripheral end
`timescale 1ns/10ps
interface three_wire_if;
  logic dev_sck_o;  // device clock drive value
  logic dev_sck_oe; // device drives clock
  logic per_sck_o;  // peripheral clock drive value
  logic per_sck_oe; // peripheral drives clock
  logic sck;        // resolved clock level, idle high
  logic dev_so;     // device serial out
  logic per_so;     // peripheral serial out

  // clock line pulled high when nobody drives
  assign sck = dev_sck_oe ? dev_sck_o : (per_sck_oe ? per_sck_o : 1'b1);

  modport device (
    output dev_sck_o, dev_sck_oe, dev_so,
    input  sck, per_so
  );
  modport peripheral (
    output per_sck_o, per_sck_oe, per_so,
    input  sck, dev_so
  );
endinterface

// File: core/sync_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0]    wr_reg;       // write pointer
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;       // read pointer
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;      // fill level
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and level update
  always_comb
  begin
    wr_next  = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
    rd_next  = pop ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // registers; storage has no reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end
endmodule

// File: core/serial_device.sv
// device end: cpu register port, baud generator and shift engine
// Functional notes
// - prescaler source fx over 2^n, codes 0-7
// - reset clears baud control to zero
// - software avoids baud writes mid transfer
// - software avoids n=1 at 5 MHz
// - internal sck equals fx over 2^(n+1); code gives fx over 2^(n+2)
// - external clock ignores baud control
// - software sets clock pin input for external
// - eight bits per transfer, full duplex
// - shift out on falling sck edge
// - sample serial input on rising sck edge
// - stop after eighth bit, raise done irq
// - tx write starts transfer when enabled, idle
// - enabling after tx write starts nothing
// - software halts transfers before mode change
// - done irq shares uart slot, vector, flags
// - unmasked request releases standby
// - clock source bit: 0 pin, 1 internal
// - order bit: 0 msb first, 1 lsb first
// - software keeps uart mode at zero
`timescale 1ns/10ps
module serial_device (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // cpu register port
  input  wire logic [15:0] addr,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  wr_data,
  output      logic [7:0]  rd_data,
  // interrupt outputs and acknowledge input
  output      logic        xfer_done_irq,
  output      logic        irq_req,
  output      logic        standby_release,
  output      logic [15:0] irq_vector,
  output      logic [3:0]  irq_priority,
  input  wire logic        irq_ack,
  // uart receive completion shares the request flag
  input  wire logic        uart_rx_done_irq,
  // link
  three_wire_if.device     link
);
  logic [7:0] mode_reg;          // serial_mode_reg
  logic [7:0] mode_next;
  logic [7:0] baud_reg;          // baud_prescale_control
  logic [7:0] baud_next;
  logic [7:0] uart_reg;          // uart_mode_reg, kept for readback
  logic [7:0] uart_next;
  logic       flag_reg;          // rx_req_flag
  logic       flag_next;
  logic       mask_reg;          // rx_mask_flag
  logic       mask_next;
  logic [7:0] tx_reg;            // tx_shift_reg
  logic [7:0] tx_next;
  logic [7:0] rx_reg;            // rx_buffer_reg
  logic [7:0] rx_next;
  logic       so_reg;            // serial out latch
  logic       so_next;
  logic [3:0] bits_reg;          // bits completed
  logic [3:0] bits_next;
  logic [8:0] div_reg;           // baud divider
  logic [8:0] div_next;
  logic       sck_reg;           // generated clock, idle high
  logic       sck_next;
  logic       prev_reg;          // last seen clock level
  logic       prev_next;
  logic       busy_reg;
  logic       busy_next;
  logic [8:0] half;              // half period in fx cycles
  logic       internal;
  logic       lsb_first;
  logic       fall;
  logic       rise;
  logic       done;
  logic       level;

  assign internal  = mode_reg[three_wire_pkg::MODE_CLKSRC_BIT];
  assign lsb_first = mode_reg[three_wire_pkg::MODE_ORDER_BIT];
  // half period 2^(n+1) fx cycles gives fx/2^(n+2)
  assign half  = 9'h001 << (baud_reg[three_wire_pkg::BAUD_SEL_MSB:
                                     three_wire_pkg::BAUD_SEL_LSB] + 4'h1);
  // external pin used as is, baud setting ignored
  assign level = internal ? sck_reg : link.sck;
  assign fall  = prev_reg && !level;
  assign rise  = !prev_reg && level;
  assign done  = busy_reg && rise && (bits_reg == three_wire_pkg::FRAME_BITS
                                                  - 4'h1);

  // outputs
  assign link.dev_sck_o  = sck_reg;
  assign link.dev_sck_oe = internal &&
                           mode_reg[three_wire_pkg::MODE_ENABLE_BIT];
  assign link.dev_so     = so_reg;
  assign xfer_done_irq   = done;
  assign irq_req         = flag_reg && !mask_reg;
  assign standby_release = irq_req;
  assign irq_vector      = three_wire_pkg::IRQ_VECTOR;
  assign irq_priority    = three_wire_pkg::IRQ_PRIORITY;

  // read mux, rx buffer shares the tx address
  always_comb
  begin
    unique case (addr)
      three_wire_pkg::MODE_ADDR:     rd_data = mode_reg;
      three_wire_pkg::BAUD_ADDR:     rd_data = baud_reg;
      three_wire_pkg::TX_ADDR:       rd_data = rx_reg;
      three_wire_pkg::UART_ADDR:     rd_data = uart_reg;
      three_wire_pkg::IRQ_FLAG_ADDR:
        rd_data = 8'(flag_reg) << three_wire_pkg::IRQ_RX_BIT;
      three_wire_pkg::IRQ_MASK_ADDR:
        rd_data = 8'(mask_reg) << three_wire_pkg::IRQ_RX_BIT;
      default:                       rd_data = 8'h00;
    endcase
  end

  // register writes, shift engine and baud generator
  always_comb
  begin
    mode_next = mode_reg;
    baud_next = baud_reg;
    uart_next = uart_reg;
    mask_next = mask_reg;
    flag_next = flag_reg;
    tx_next   = tx_reg;
    rx_next   = rx_reg;
    so_next   = so_reg;
    bits_next = bits_reg;
    div_next  = div_reg;
    sck_next  = sck_reg;
    busy_next = busy_reg;
    prev_next = level;
    if (wr_en)
    begin
      unique case (addr)
        three_wire_pkg::MODE_ADDR:     mode_next = wr_data & 8'h86;
        three_wire_pkg::BAUD_ADDR:     baud_next = wr_data & 8'hF0;
        three_wire_pkg::UART_ADDR:     uart_next = wr_data;
        three_wire_pkg::IRQ_FLAG_ADDR:
          flag_next = wr_data[three_wire_pkg::IRQ_RX_BIT];
        three_wire_pkg::IRQ_MASK_ADDR:
          mask_next = wr_data[three_wire_pkg::IRQ_RX_BIT];
        default: ;
      endcase
    end
    if (irq_ack)
      flag_next = 1'b0;
    // start only on the tx write itself, enable must already be set
    if (wr_en && addr == three_wire_pkg::TX_ADDR && !busy_reg)
    begin
      tx_next = wr_data;
      if (mode_reg[three_wire_pkg::MODE_ENABLE_BIT] && level)
      begin
        busy_next = 1'b1;
        bits_next = 4'h0;
        div_next  = 9'h000;
        so_next   = lsb_first ? wr_data[0] : wr_data[7]; // first bit ready
      end
    end
    if (!mode_reg[three_wire_pkg::MODE_ENABLE_BIT])
    begin
      busy_next = 1'b0; // disabling aborts
      sck_next  = 1'b1;
    end
    else if (busy_reg)
    begin
      // internal generator toggles every half period
      if (internal)
      begin
        if (div_reg + 9'h001 >= half)
        begin
          div_next = 9'h000;
          sck_next = !sck_reg;
        end
        else
          div_next = div_reg + 9'h001;
      end
      if (fall && bits_reg != 4'h0) // later bits leave on falls
        so_next = lsb_first ? tx_reg[0] : tx_reg[7];
      if (rise) // sample, then shift for next bit
      begin
        rx_next   = lsb_first ? {link.per_so, rx_reg[7:1]}
                              : {rx_reg[6:0], link.per_so};
        tx_next   = lsb_first ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
        bits_next = bits_reg + 4'h1;
      end
      if (done) // stop after the eighth bit
      begin
        busy_next = 1'b0;
        sck_next  = 1'b1;
      end
    end
    if (done || uart_rx_done_irq)
      flag_next = 1'b1; // set wins over clear
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= three_wire_pkg::MODE_RESET;
      baud_reg <= three_wire_pkg::BAUD_RESET;
      uart_reg <= three_wire_pkg::UART_RESET;
      flag_reg <= 1'b0;
      mask_reg <= 1'b1;
      tx_reg   <= 8'h00;
      rx_reg   <= 8'h00;
      so_reg   <= 1'b1;
      bits_reg <= 4'h0;
      div_reg  <= 9'h000;
      sck_reg  <= 1'b1;
      prev_reg <= 1'b1;
      busy_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      baud_reg <= baud_next;
      uart_reg <= uart_next;
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      tx_reg   <= tx_next;
      rx_reg   <= rx_next;
      so_reg   <= so_next;
      bits_reg <= bits_next;
      div_reg  <= div_next;
      sck_reg  <= sck_next;
      prev_reg <= prev_next;
      busy_reg <= busy_next;
    end
  end
endmodule

// File: core/serial_peripheral.sv
// peripheral end: clocked serial port with an 8-word transmit fifo
`timescale 1ns/10ps
module serial_peripheral (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // user side
  input  wire logic       drive_clock,  // 1: this end makes the clock
  input  wire logic [7:0] half_period,  // fx cycles per clock half
  input  wire logic       tx_valid,
  output      logic       tx_ready,
  input  wire logic [7:0] tx_data,
  output      logic       rx_valid,
  output      logic [7:0] rx_data,
  // link
  three_wire_if.peripheral link
);
  logic       f_valid;
  logic [7:0] f_data;
  logic       f_pop;
  logic [7:0] sh_reg;  // shift register, msb first
  logic [7:0] sh_next;
  logic [7:0] in_reg;
  logic [7:0] in_next;
  logic [3:0] bits_reg;
  logic [3:0] bits_next;
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic       sck_reg;
  logic       sck_next;
  logic       prev_reg;
  logic       fall;
  logic       rise;
  logic       start;
  logic       so_reg;
  logic       so_next;
  logic       rv_reg;
  logic       rv_next;
  logic [7:0] rd_reg;
  logic [7:0] rd_next;
  three_wire_pkg::xfer_state_t st_reg;
  three_wire_pkg::xfer_state_t st_next;

  // buffer stalls the user when the link is slow
  sync_fifo #(
    .WIDTH (three_wire_pkg::FIFO_WIDTH),
    .DEPTH (three_wire_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  assign link.per_sck_o  = sck_reg;
  assign link.per_sck_oe = drive_clock;
  assign link.per_so     = so_reg;
  assign rx_valid        = rv_reg;
  assign rx_data         = rd_reg;
  assign fall  = prev_reg && !link.sck;
  assign rise  = !prev_reg && link.sck;
  // as follower, a frame opens on the first fall
  assign start = (st_reg == three_wire_pkg::XF_IDLE) &&
                 (drive_clock ? f_valid : fall);
  assign f_pop = start && f_valid;

  // frame engine: eight low pulses, idle high, msb first
  always_comb
  begin
    st_next   = st_reg;
    sh_next   = sh_reg;
    in_next   = in_reg;
    bits_next = bits_reg;
    div_next  = div_reg;
    sck_next  = sck_reg;
    so_next   = so_reg;
    rv_next   = 1'b0;
    rd_next   = rd_reg;
    unique case (st_reg)
      three_wire_pkg::XF_IDLE:
      begin
        sck_next = 1'b1;
        if (start)
        begin
          sh_next   = {f_data[6:0], 1'b0};
          so_next   = f_data[7];
          bits_next = 4'h0;
          div_next  = 8'h00;
          st_next   = three_wire_pkg::XF_LOW;
          sck_next  = 1'b0;
        end
      end
      three_wire_pkg::XF_LOW:
      begin
        if (drive_clock ? div_reg + 8'h01 >= half_period : rise)
        begin
          div_next = 8'h00;
          sck_next = 1'b1;
          in_next  = {in_reg[6:0], link.dev_so}; // sample at rise
          bits_next = bits_reg + 4'h1;
          st_next  = three_wire_pkg::XF_HIGH;
        end
        else
          div_next = div_reg + 8'h01;
      end
      three_wire_pkg::XF_HIGH:
      begin
        if (drive_clock ? div_reg + 8'h01 >= half_period
                        : fall || bits_reg == three_wire_pkg::FRAME_BITS)
        begin
          div_next = 8'h00;
          if (bits_reg == three_wire_pkg::FRAME_BITS)
          begin
            rv_next = 1'b1;
            rd_next = in_reg;
            st_next = three_wire_pkg::XF_IDLE;
          end
          else
          begin
            sck_next = 1'b0;
            so_next  = sh_reg[7];
            sh_next  = {sh_reg[6:0], 1'b0};
            st_next  = three_wire_pkg::XF_LOW;
          end
        end
        else
          div_next = div_reg + 8'h01;
      end
      default: st_next = three_wire_pkg::XF_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg   <= three_wire_pkg::XF_IDLE;
      sh_reg   <= 8'h00;
      in_reg   <= 8'h00;
      bits_reg <= 4'h0;
      div_reg  <= 8'h00;
      sck_reg  <= 1'b1;
      prev_reg <= 1'b1;
      so_reg   <= 1'b1;
      rv_reg   <= 1'b0;
      rd_reg   <= 8'h00;
    end
    else
    begin
      st_reg   <= st_next;
      sh_reg   <= sh_next;
      in_reg   <= in_next;
      bits_reg <= bits_next;
      div_reg  <= div_next;
      sck_reg  <= sck_next;
      prev_reg <= link.sck;
      so_reg   <= so_next;
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
    end
  end
endmodule

// File: tb/three_wire_chk.sv
// wire-level assertions for the three-wire serial link
`timescale 1ns/10ps
module three_wire_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link signals
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe,
  input wire logic per_sck_o,
  input wire logic per_sck_oe,
  input wire logic sck,
  input wire logic dev_so,
  input wire logic per_so
);
  localparam int IDLE_GAP = 520; // longer than any half period: idle only
  logic       sck_d_reg;     // line level one cycle ago
  logic       sck_d_next;
  logic [9:0] hi_cnt_reg;    // cycles the line has stayed high
  logic [9:0] hi_cnt_next;
  logic [9:0] lo_cnt_reg;    // cycles the line has stayed low
  logic [9:0] lo_cnt_next;
  logic [3:0] fall_cnt_reg;  // falls since the last long idle
  logic [3:0] fall_cnt_next;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // next values; counters saturate so a stuck line cannot wrap
  always_comb
  begin
    sck_d_next  = sck;
    hi_cnt_next = 10'h000;
    if (sck)
      hi_cnt_next = (hi_cnt_reg > 10'(IDLE_GAP)) ? hi_cnt_reg
                                                 : hi_cnt_reg + 10'h001;
    lo_cnt_next = 10'h000;
    if (!sck)
      lo_cnt_next = (lo_cnt_reg == 10'h3FF) ? lo_cnt_reg : lo_cnt_reg + 10'h001;
    fall_cnt_next = (hi_cnt_reg == 10'(IDLE_GAP)) ? 4'h0 : fall_cnt_reg;
    if (sck_d_reg && !sck && fall_cnt_next != 4'hF)
      fall_cnt_next = fall_cnt_next + 4'h1;
  end

  // register the trackers; the line idles high out of reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_d_reg    <= 1'b1;
      hi_cnt_reg   <= 10'h000;
      lo_cnt_reg   <= 10'h000;
      fall_cnt_reg <= 4'h0;
    end
    else
    begin
      sck_d_reg    <= sck_d_next;
      hi_cnt_reg   <= hi_cnt_next;
      lo_cnt_reg   <= lo_cnt_next;
      fall_cnt_reg <= fall_cnt_next;
    end
  end

  a_single_driver: assert property (
    per_sck_oe |-> !dev_sck_oe) else $error("two clock drivers");
  a_idle_after_reset: assert property (
    $rose(rst_n) |-> sck && dev_so) else $error("line not idle at reset");
  a_low_min: assert property (
    $fell(sck) |=> !sck) else $error("clock low phase too short");
  a_high_min: assert property (
    $rose(sck) |=> sck) else $error("clock high phase too short");
  a_low_bounded: assert property (
    !sck |-> lo_cnt_reg < 10'h100) else $error("clock low phase too long");
  a_eight_pulses: assert property (
    hi_cnt_reg == 10'(IDLE_GAP) |-> fall_cnt_reg inside {4'h0, 4'h8})
    else $error("frame without eight clock pulses");
  a_dev_so_rise: assert property (
    $rose(sck) |-> $stable(dev_so)) else $error("device data moved on rise");
  a_per_so_rise: assert property (
    $rose(sck) |-> $stable(per_so)) else $error("peer data moved on rise");
endmodule

// File: tb/testbench.sv
// self-checking bench: device and peripheral ends joined over one link
`timescale 1ns/10ps
module testbench;
  logic        clk;              // 250 MHz system clock
  logic        rst_n;            // async reset
  logic [15:0] addr;             // cpu address
  logic        wr_en;            // cpu write strobe
  logic        rd_en;            // marks a read to compare
  logic [7:0]  wr_data;          // cpu write data
  logic [7:0]  rd_data;          // cpu read data
  logic        xfer_done_irq;    // end of frame pulse
  logic        irq_req;          // unmasked request
  logic        standby_release;  // wake signal
  logic [15:0] irq_vector;       // shared vector
  logic [3:0]  irq_priority;     // shared priority
  logic        irq_ack;          // request acknowledge
  logic        uart_rx_done_irq; // second source of the shared flag
  logic        drive_clock;      // peripheral makes the clock
  logic [7:0]  half_period;      // peripheral half period
  logic        tx_valid;         // fifo fill side
  logic        tx_ready;
  logic [7:0]  tx_data;
  logic        rx_valid;         // byte taken by the peripheral
  logic [7:0]  rx_data;
  int          err_total = 0;    // mismatches
  int          tests_run = 0;    // comparisons
  int          done_cnt = 0;     // frames ended
  int          seed = 32'h2BDFA3B8;
  int          cyc = 0;          // monitor time base
  int          nf = 0;           // clock falls in this frame
  int          t0 = 0;
  int          per = 0;          // measured clock period
  logic        sck_prev = 1'b1;
  logic [15:0] rd_q[$];          // expected reads
  logic [15:0] rx_q[$];          // expected peripheral bytes
  logic [15:0] per_q[$];         // expected clock periods
  logic [7:0]  fifo_q[$];        // bytes waiting in the fifo

  three_wire_if link ();
  serial_device serial_device_inst (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wr_data(wr_data), .rd_data(rd_data), .xfer_done_irq(xfer_done_irq),
    .irq_req(irq_req), .standby_release(standby_release),
    .irq_vector(irq_vector), .irq_priority(irq_priority), .irq_ack(irq_ack),
    .uart_rx_done_irq(uart_rx_done_irq), .link(link));
  serial_peripheral serial_peripheral_inst (
    .clk(clk), .rst_n(rst_n), .drive_clock(drive_clock),
    .half_period(half_period), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .link(link));
  three_wire_chk three_wire_chk_inst (
    .clk(clk), .rst_n(rst_n), .dev_sck_o(link.dev_sck_o),
    .dev_sck_oe(link.dev_sck_oe), .per_sck_o(link.per_sck_o),
    .per_sck_oe(link.per_sck_oe), .sck(link.sck), .dev_so(link.dev_so),
    .per_so(link.per_so));

  // free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test;
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // every comparison funnels through here
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // an empty queue yields unknowns so a surplus result mismatches
  function automatic logic [15:0] take(ref logic [15:0] q[$]);
    if (q.size() == 0)
      return 16'hXXXX;
    return q.pop_front();
  endfunction

  function automatic logic [7:0] rev(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = v[7-i];
    return r;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // read is compared by the monitor at the edge where rd_en is seen
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    rd_q.push_back({8'h00, e});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  // valid and data held until the edge that samples ready high
  task automatic push(input logic [7:0] v);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data  <= v;
    @(posedge clk);
    while (tx_ready !== 1'b1)
      @(posedge clk);
    tx_valid <= 1'b0;
  endtask

  // one full-duplex frame; poke tries a second write while busy
  task automatic xfer(input logic [7:0] mode, input logic [15:0] pe,
                      input logic [7:0] p, input logic late, input logic poke);
    logic [7:0] d;
    int         k;
    d = 8'($random(seed));
    per_q.push_back(pe);
    rx_q.push_back({8'h00, mode[2] ? rev(d) : d});
    wr(three_wire_pkg::TX_ADDR, d);
    if (late)
      push(p);
    if (poke)
      wr(three_wire_pkg::TX_ADDR, ~d);
    k = 0;
    while (xfer_done_irq !== 1'b1 && k < 5000)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 5000)
      err_total++; // frame lost
    repeat (600) @(posedge clk);
    rd(three_wire_pkg::TX_ADDR, mode[2] ? rev(p) : p);
  endtask

  // monitor: reads, received bytes, clock period per frame
  always @(posedge clk)
  begin
    cyc++;
    if (rd_en === 1'b1)
      check("rd_data", {8'h00, rd_data}, take(rd_q));
    if (rx_valid === 1'b1)
      check("rx_data", {8'h00, rx_data}, take(rx_q));
    if (sck_prev === 1'b1 && link.sck === 1'b0)
    begin
      nf++;
      if (nf == 1)
        t0 = cyc;
      if (nf == 2)
        per = cyc - t0;
    end
    sck_prev = link.sck;
    if (xfer_done_irq === 1'b1)
    begin
      done_cnt++;
      check("sck_period", 16'(per), take(per_q));
      nf = 0;
    end
  end

  // watchdog: well past the longest expected run
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end

  // main sequence
  initial
  begin
    logic [7:0] p;
    logic [7:0] h;
    int         nd;
    rst_n = 1'b0;
    addr = three_wire_pkg::TX_ADDR;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = 8'h00;
    irq_ack = 1'b0;
    uart_rx_done_irq = 1'b0;
    drive_clock = 1'b0;
    half_period = 8'h04;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(three_wire_pkg::BAUD_ADDR, 8'h00);
    rd(three_wire_pkg::MODE_ADDR, 8'h00);
    rd(three_wire_pkg::IRQ_MASK_ADDR, 8'h10);
    rd(three_wire_pkg::IRQ_FLAG_ADDR, 8'h00);
    wr(three_wire_pkg::UART_ADDR, 8'h00);
    wr(16'hFF75, 8'h5A);
    rd(three_wire_pkg::BAUD_ADDR, 8'h00);
    // fill the peripheral fifo while nobody clocks
    for (int i = 0; i < 8; i++)
    begin
      p = 8'($random(seed));
      push(p);
      fifo_q.push_back(p);
    end
    @(posedge clk);
    check("fifo_full", {15'h0000, tx_ready}, 16'h0000);
    // drain it over every prescale code, internal clock, msb first
    wr(three_wire_pkg::MODE_ADDR, 8'h82);
    for (int c = 0; c < 8; c++)
    begin
      wr(three_wire_pkg::BAUD_ADDR, {1'b0, 3'(c), 4'h0});
      rd(three_wire_pkg::BAUD_ADDR, {1'b0, 3'(c), 4'h0});
      xfer(8'h82, 16'h0004 << c, fifo_q.pop_front(), 1'b0, c == 2);
    end
    p = 8'($random(seed));
    push(p);
    wr(three_wire_pkg::MODE_ADDR, 8'h86);
    xfer(8'h86, 16'h0200, p, 1'b0, 1'b0);
    // external clock: pin released by the device first
    wr(three_wire_pkg::MODE_ADDR, 8'h80);
    @(posedge clk);
    drive_clock <= 1'b1;
    for (int j = 0; j < 3; j++)
    begin
      h = 8'h04 + 8'($random(seed) & 7);
      half_period <= h;
      wr(three_wire_pkg::BAUD_ADDR, {1'b0, 3'($random(seed)), 4'h0});
      xfer(8'h80, {7'h00, h, 1'b0}, 8'($random(seed)), 1'b1, 1'b0);
    end
    @(posedge clk);
    drive_clock <= 1'b0;
    // enabling after the data write must not start a frame
    wr(three_wire_pkg::MODE_ADDR, 8'h02);
    wr(three_wire_pkg::TX_ADDR, 8'hA5);
    wr(three_wire_pkg::MODE_ADDR, 8'h82);
    nd = done_cnt;
    repeat (100) @(posedge clk);
    check("late_enable", 16'(done_cnt - nd), 16'h0000);
    check("sck_idle", {15'h0000, link.sck}, 16'h0001);
    // shared request flag, mask, acknowledge and second source
    rd(three_wire_pkg::IRQ_FLAG_ADDR, 8'h10);
    @(posedge clk);
    check("irq_masked", {15'h0000, irq_req}, 16'h0000);
    wr(three_wire_pkg::IRQ_MASK_ADDR, 8'hEF);
    @(posedge clk);
    check("irq_req", {15'h0000, irq_req}, 16'h0001);
    check("standby", {15'h0000, standby_release}, 16'h0001);
    check("vector", irq_vector, 16'h000C);
    check("priority", {12'h000, irq_priority}, 16'h0004);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    @(posedge clk);
    check("irq_ack", {15'h0000, irq_req}, 16'h0000);
    uart_rx_done_irq <= 1'b1;
    @(posedge clk);
    uart_rx_done_irq <= 1'b0;
    @(posedge clk);
    check("uart_share", {15'h0000, irq_req}, 16'h0001);
    wr(three_wire_pkg::IRQ_FLAG_ADDR, 8'h00);
    @(posedge clk);
    check("flag_clear", {15'h0000, standby_release}, 16'h0000);
    stop_test();
  end
endmodule
